// File: src/timer2_capture_reload.sv
// Notes on behaviour
// RQ1: Overflow sets control bit 7 unless a serial clock select is set.
// RQ2: A qualifying pin falling edge sets control bit 6; software clears it.
// RQ3: Control bit 5 picks receive clock: Timer1 overflow or this overflow.
// RQ4: Control bit 4 picks transmit clock: Timer1 overflow or this overflow.
// RQ5: Pin edges act only with bit 3 set and both serial selects zero.
// RQ6: Timer and counter setting both count once every two clocks.
// RQ7: Bit 0 zero: reload on overflow and on enabled pin edges.
// RQ8: Bit 0 one: capture count on enabled pin edges.
// RQ9: Any serial select forces auto-reload on overflow, ignoring bit 0.
// RQ10: Reload/capture value is two read/write bytes, reset to zero.
// RQ11: Running count is two read/write bytes, reset to zero.
// RQ12: Run control zero holds the count; one lets it advance. With bit 0 zero, enabled pin edges still reload it while run is zero.
// RQ13: Reload copies value to count; capture copies count to value.
`timescale 1ns/10ps
`include "timer2_defines.svh"
module timer2_capture_reload
   import timer2_pkg::*;
(
   input  wire logic                   mclk,
   input  wire logic                   rst,
   input  wire logic [`APB_ADDR_W-1:0] paddr,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic                   trigger_pin,
   input  wire logic                   timer1_overflow,
   output logic                        serial_rx_clock,
   output logic                        serial_tx_clock,
   output logic                        irq
);

   timer_state_t s_q;
   timer_state_t s_d;

   trig_if trig ();

   trig_edge u_edge (
      .mclk        (mclk),
      .rst         (rst),
      .trigger_pin (trigger_pin),
      .trig        (trig.src)
   );

   function automatic logic addr_mapped(
      input logic [`APB_ADDR_W-1:0] a
   );
      logic [7:0] idx;
      idx = a[9:2];
      addr_mapped = (a[1:0] == 2'h0) && (a[`APB_ADDR_W-1:10] == 2'h0) &&
                    (idx == `IDX_CONTROL    || idx == `IDX_RCAP_LOW   ||
                     idx == `IDX_RCAP_HIGH  || idx == `IDX_COUNT_LOW  ||
                     idx == `IDX_COUNT_HIGH || idx == `IDX_IRQ_STATUS ||
                     idx == `IDX_IRQ_MASK);
   endfunction

   function automatic logic [7:0] read_mux(
      input timer_state_t          st,
      input logic [`APB_ADDR_W-1:0] a
   );
      read_mux = 8'h00;
      unique case (a[9:2])
         `IDX_CONTROL:    read_mux = st.ctrl;
         `IDX_RCAP_LOW:   read_mux = st.rcap[7:0];
         `IDX_RCAP_HIGH:  read_mux = st.rcap[15:8];
         `IDX_COUNT_LOW:  read_mux = st.count[7:0];
         `IDX_COUNT_HIGH: read_mux = st.count[15:8];
         `IDX_IRQ_STATUS: read_mux = {6'h00, st.irq_stat};
         `IDX_IRQ_MASK:   read_mux = {6'h00, st.irq_mask};
         default:         read_mux = 8'h00;
      endcase
   endfunction

   logic       access;
   logic       wr_go;
   logic       serial_sel;
   logic       tick;
   logic       ovf;
   logic       edge_ev;
   logic       do_capture;
   logic       do_reload;
   logic       ovf_flag_set;
   logic [7:0] wbyte;

   always_comb begin
      s_d     = s_q;
      access  = psel & penable;
      wbyte   = pwdata[7:0];
      wr_go   = access & s_q.pready & pwrite & ~s_q.pslverr;

      // Answer one cycle into the access phase; the write lands on the
      // edge at which the master sees pready, so the bus view is coherent.
      s_d.pready  = access & ~s_q.pready;
      s_d.pslverr = 1'b0;
      if (access && !s_q.pready) begin
         s_d.pslverr = ~addr_mapped(paddr);
         // A refused address reads as zero, even where its index decodes.
         s_d.prdata  = addr_mapped(paddr) ?
                       {24'h000000, read_mux(s_q, paddr)} : 32'h00000000;
      end

      serial_sel = s_q.ctrl[`BIT_RX_SEL] | s_q.ctrl[`BIT_TX_SEL];

      // The prescaler runs only while counting, so a stopped timer
      // restarts with a full two-clock interval.
      tick = s_q.ctrl[`BIT_RUN] & s_q.prescale; // RQ6 RQ12
      s_d.prescale = s_q.ctrl[`BIT_RUN] & ~s_q.prescale; // RQ6
      ovf = tick && (s_q.count == `COUNT_ALL_ONES); // RQ13

      edge_ev = trig.fall & s_q.ctrl[`BIT_PIN_EN] & ~serial_sel; // RQ5
      do_capture = edge_ev & s_q.ctrl[`BIT_CAP_SEL]; // RQ8
      do_reload  = (ovf & (serial_sel | ~s_q.ctrl[`BIT_CAP_SEL])) | // RQ9
                   (edge_ev & ~s_q.ctrl[`BIT_CAP_SEL]); // RQ7

      if (do_reload) begin
         s_d.count = s_q.rcap; // RQ13
      end else if (tick) begin
         s_d.count = s_q.count + `COUNT_STEP; // RQ12
      end
      if (do_capture) begin
         s_d.rcap = s_q.count; // RQ13
      end

      // A software write to a data byte overrides the hardware update
      // in the same cycle.
      if (wr_go) begin
         unique case (paddr[9:2])
            `IDX_CONTROL:    s_d.ctrl = wbyte;
            `IDX_RCAP_LOW:   s_d.rcap[7:0] = wbyte; // RQ10
            `IDX_RCAP_HIGH:  s_d.rcap[15:8] = wbyte; // RQ10
            `IDX_COUNT_LOW:  s_d.count[7:0] = wbyte; // RQ11
            `IDX_COUNT_HIGH: s_d.count[15:8] = wbyte; // RQ11
            `IDX_IRQ_STATUS: s_d.irq_stat = s_q.irq_stat & ~wbyte[1:0];
            `IDX_IRQ_MASK:   s_d.irq_mask = wbyte[1:0];
            default:         s_d.ctrl = s_d.ctrl;
         endcase
      end

      // Hardware sets come last so an event is never lost to a clear.
      ovf_flag_set = ovf & ~serial_sel;
      if (ovf_flag_set) begin
         s_d.ctrl[`BIT_OVF_FLAG] = 1'b1; // RQ1
         s_d.irq_stat[`IRQ_OVF]  = 1'b1;
      end
      if (edge_ev) begin
         s_d.ctrl[`BIT_EDGE_FLAG] = 1'b1; // RQ2
         s_d.irq_stat[`IRQ_EDGE]  = 1'b1;
      end

      s_d.irq = |(s_d.irq_stat & s_d.irq_mask);

      s_d.rx_clk = s_q.ctrl[`BIT_RX_SEL] ? ovf : timer1_overflow; // RQ3
      s_d.tx_clk = s_q.ctrl[`BIT_TX_SEL] ? ovf : timer1_overflow; // RQ4
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata          = s_q.prdata;
   assign pready          = s_q.pready;
   assign pslverr         = s_q.pslverr;
   assign serial_rx_clock = s_q.rx_clk;
   assign serial_tx_clock = s_q.tx_clk;
   assign irq             = s_q.irq;

endmodule

// File: src/timer2_defines.svh
`ifndef TIMER2_DEFINES_SVH
`define TIMER2_DEFINES_SVH

// Register indices; byte address on the bus is four times the index.
`define IDX_CONTROL      8'hC8
`define IDX_RCAP_LOW     8'hCA
`define IDX_RCAP_HIGH    8'hCB
`define IDX_COUNT_LOW    8'hCC
`define IDX_COUNT_HIGH   8'hCD
`define IDX_IRQ_STATUS   8'hC0
`define IDX_IRQ_MASK     8'hC1

// Control register bit positions.
`define BIT_OVF_FLAG     7
`define BIT_EDGE_FLAG    6
`define BIT_RX_SEL       5
`define BIT_TX_SEL       4
`define BIT_PIN_EN       3
`define BIT_RUN          2
`define BIT_CT_SEL       1
`define BIT_CAP_SEL      0

// Interrupt status and mask bit positions.
`define IRQ_OVF          0
`define IRQ_EDGE         1

`define COUNT_ALL_ONES   16'hFFFF
`define COUNT_STEP       16'h0001
`define APB_ADDR_W       12

`endif

// File: src/timer2_pkg.sv
package timer2_pkg;

   typedef struct packed {
      logic [7:0]  ctrl;
      logic [15:0] rcap;
      logic [15:0] count;
      logic        prescale;
      logic [1:0]  irq_stat;
      logic [1:0]  irq_mask;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic        irq;
      logic        rx_clk;
      logic        tx_clk;
   } timer_state_t;

   typedef struct packed {
      logic sync1;
      logic sync2;
      logic prev;
      logic fall;
   } edge_state_t;

endpackage

// File: src/trig_if.sv
`timescale 1ns/10ps
interface trig_if;
   logic fall;

   modport src (output fall);
   modport snk (input fall);
endinterface

// File: src/trig_edge.sv
`timescale 1ns/10ps
module trig_edge
   import timer2_pkg::*;
(
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic trigger_pin,
   trig_if.src       trig
);

   edge_state_t s_q;
   edge_state_t s_d;

   // The first stage feeds only the second; the edge is taken further on.
   always_comb begin
      s_d       = s_q;
      s_d.sync1 = trigger_pin;
      s_d.sync2 = s_q.sync1;
      s_d.prev  = s_q.sync2;
      s_d.fall  = s_q.prev & ~s_q.sync2;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign trig.fall = s_q.fall;

endmodule

// File: dv/timer2_capture_reload_asserts.sv
`timescale 1ns/10ps
module timer2_capture_reload_asserts (
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic [11:0] paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        serial_tx_clock,
   input wire logic        irq
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   property p_wait; psel && penable && !pready |=> pready; endproperty
   a_wait: assert property (p_wait) else $error("no answer after wait");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("ready too long");
   property p_idle; !psel |=> !pready; endproperty
   a_idle: assert property (p_idle) else $error("ready without request");
   property p_upper; pready |-> prdata[31:8] == 24'h0; endproperty
   a_upper: assert property (p_upper) else $error("upper data bits set");
   property p_err; pready && paddr == 12'h3FC |-> pslverr; endproperty
   a_err: assert property (p_err) else $error("unmapped not refused");
   property p_ok; pready && paddr == 12'h320 |-> !pslverr; endproperty
   a_ok: assert property (p_ok) else $error("mapped refused");
   property p_errr; pslverr |-> pready && prdata == 32'h0; endproperty
   a_errr: assert property (p_errr) else $error("error without ready");
   property p_rst; $past(rst) |-> !pready && !irq; endproperty
   a_rst: assert property (p_rst) else $error("outputs set after reset");
   c_irq: cover property ($rose(irq));
   c_err: cover property (pslverr);
   c_tx: cover property (serial_tx_clock);
endmodule
bind timer2_capture_reload timer2_capture_reload_asserts chk_inst (.*);

// File: dv/trig_src.sv
`timescale 1ns/10ps
module trig_src (
   input  wire logic mclk,
   input  wire logic go,
   output logic      trigger_pin,
   output logic      timer1_overflow
);
   logic [3:0] n_q = 4'h0;
   logic [3:0] low_q = 4'h0;
   // The pin idles high; a request holds it low long enough to be synced.
   always @(posedge mclk) begin
      n_q <= n_q + 4'h1;
      if (go) low_q <= 4'h6;
      else if (low_q != 4'h0) low_q <= low_q - 4'h1;
   end
   assign trigger_pin = (low_q == 4'h0);
   assign timer1_overflow = (n_q == 4'hF);
endmodule

// File: dv/timer2_capture_reload_tb.sv
`timescale 1ns/10ps
module timer2_capture_reload_tb;
   logic mclk, rst, psel, penable, pwrite, go, pready, pslverr, irq;
   logic tp, t1, rxc, txc;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0] rd, keep;
   logic err;
   int n_rx, n_tx;
   int n_errors = 0, compares = 0;
   timer2_capture_reload timer2_capture_reload_inst (.mclk(mclk), .rst(rst),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .trigger_pin(tp), .timer1_overflow(t1), .serial_rx_clock(rxc),
      .serial_tx_clock(txc), .irq(irq));
   trig_src trig_src_inst (.mclk(mclk), .go(go), .trigger_pin(tp),
      .timer1_overflow(t1));
   initial begin
      mclk = 0;
      forever #5 mclk = ~mclk;
   end
   task results;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Request is held until the edge where ready is seen high.
   task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int i;
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
      @(posedge mclk) penable <= 1;
      for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge mclk);
      if (i == 20) begin
         n_errors++;
         results();
      end
      rd = prdata[7:0];
      err = pslverr;
      psel <= 0; penable <= 0;
      @(posedge mclk);
   endtask
   task resets;
      for (int a = 12'h328; a <= 12'h334; a += 4) begin
         apb(0, a[11:0], 8'h0);
         chk(rd, 8'h00);
      end
      apb(1, 12'h3FC, 8'h5A);
      apb(0, 12'h3FC, 8'h0);
      chk({err, rd[6:0]}, 8'h80);
   endtask
   task overflow;
      apb(1, 12'h32C, 8'h12);
      apb(0, 12'h32C, 8'h0);
      chk(rd, 8'h12);
      apb(1, 12'h330, 8'hFE);
      apb(1, 12'h334, 8'hFF);
      apb(1, 12'h304, 8'h01);
      apb(1, 12'h320, 8'h04);
      repeat (10) @(posedge mclk);
      chk({7'h0, irq}, 8'h01);
      apb(0, 12'h320, 8'h0);
      chk(rd, 8'h84);
      apb(0, 12'h334, 8'h0);
      chk(rd, 8'h12);
      apb(1, 12'h300, 8'h01);
      apb(1, 12'h320, 8'h00);
      chk({7'h0, irq}, 8'h00);
   endtask
   // Counts serial clock pulses over a window; 32 cycles hold whole periods.
   task count32;
      n_rx = 0;
      n_tx = 0;
      repeat (32) begin
         @(posedge mclk);
         n_rx += rxc;
         n_tx += txc;
      end
   endtask
   task serial;
      apb(1, 12'h328, 8'hFE);
      apb(1, 12'h32C, 8'hFF);
      apb(1, 12'h330, 8'hFE);
      apb(1, 12'h334, 8'hFF);
      apb(1, 12'h320, 8'h10);
      count32();
      chk(n_tx[7:0], 8'h00);
      chk(n_rx[7:0], 8'h02);
      apb(1, 12'h320, 8'h2D);
      go <= 1;
      @(posedge mclk) go <= 0;
      repeat (8) @(posedge mclk);
      count32();
      chk(n_rx[7:0], 8'h08);
      chk(n_tx[7:0], 8'h02);
      apb(0, 12'h320, 8'h0);
      chk(rd, 8'h2D);
      apb(1, 12'h320, 8'h00);
   endtask
   task capture;
      apb(1, 12'h334, 8'h56);
      apb(1, 12'h330, 8'h00);
      apb(1, 12'h320, 8'h0D);
      go <= 1;
      @(posedge mclk) go <= 0;
      repeat (20) @(posedge mclk);
      apb(0, 12'h32C, 8'h0);
      chk(rd, 8'h56);
      apb(0, 12'h320, 8'h0);
      chk(rd, 8'h4D);
      apb(1, 12'h320, 8'h40);
      apb(0, 12'h300, 8'h0);
      chk(rd, 8'h02);
      apb(0, 12'h330, 8'h0);
      keep = rd;
      repeat (6) @(posedge mclk);
      apb(0, 12'h330, 8'h0);
      chk(rd, keep);
   endtask
   initial begin
      rst = 1; psel = 0; penable = 0; pwrite = 0; go = 0;
      paddr = 12'h0; pwdata = 32'h0;
      repeat (2) @(posedge mclk);
      rst <= 0;
      @(posedge mclk);
      resets();
      overflow();
      capture();
      serial();
      results();
   end
endmodule
